// [include/bmd_pkg.sv]
// Package: address map, pin functions and constants for the bank-0 decoder
package bmd_pkg;

   // ----------------------------------------------------------------
   // Address space
   // ----------------------------------------------------------------
   localparam int BMD_ADDR_W = 24;
   localparam int BMD_BANK_W = 8;
   localparam logic [7:0] BMD_BANK_ZERO = 8'h00;
   localparam logic [15:0] BMD_SFR_LAST = 16'h007f;
   localparam logic [15:0] BMD_RAM_FIRST = 16'h0080;
   localparam logic [15:0] BMD_RAM_LAST = 16'h027f;
   localparam logic [15:0] BMD_ROM_FIRST = 16'hc000;
   localparam logic [15:0] BMD_VEC_FIRST = 16'hffd6;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] BMD_DP_BASE_RST = 16'h0000;
   localparam logic [7:0] BMD_PORT_RST = 8'h00;
   localparam logic BMD_PHI_SEL_RST = 1'b0;

   // ----------------------------------------------------------------
   // Pin positions within ports
   // ----------------------------------------------------------------
   localparam int BMD_P3_RW = 0;
   localparam int BMD_P3_BHE = 1;
   localparam int BMD_P3_ALE = 2;
   localparam int BMD_P3_HOLD_ACK_OUT = 3;
   localparam int BMD_P4_HOLD = 0;
   localparam int BMD_P4_RDY = 1;
   localparam int BMD_P4_PHI = 2;
   localparam int BMD_P7_TRIG = 7;

   typedef enum logic [1:0]
   {
      BMD_MODE_SINGLE,
      BMD_MODE_EXPAND,
      BMD_MODE_MICRO
   } bmd_mode_e;

   typedef enum logic [2:0]
   {
      BMD_SEL_SFR,
      BMD_SEL_RAM,
      BMD_SEL_ROM,
      BMD_SEL_EXT,
      BMD_SEL_NONE
   } bmd_sel_e;

   // CPU bus request
   typedef struct packed
   {
      logic valid;
      logic direct;
      logic write;
      logic byte_hi;
      logic [23:0] addr;
      logic [7:0] dp_offset;
   } bmd_req_s;

   // Decoded selection
   typedef struct packed
   {
      logic sfr;
      logic ram;
      logic rom;
      logic vector;
      logic ext;
      logic [23:0] addr;
   } bmd_dec_s;

   // One 8-bit port's pins
   typedef struct packed
   {
      logic [7:0] out;
      logic [7:0] oe;
   } bmd_pin_s;

endpackage : bmd_pkg

// [hdl/bmd_port_bit.sv]
// Module: one general-purpose port bit with direction control
`timescale 1ns/1ps
module bmd_port_bit
   import bmd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic data_we_i,
   input wire logic dir_we_i,
   input wire logic wdata_i,
   output logic out_o,
   output logic oe_o
);

   logic out_reg;
   logic out_next;
   logic oe_reg;
   logic oe_next;

   // ----------------------------------------------------------------
   // Latch and direction
   // ----------------------------------------------------------------
   always_comb
   begin
      out_next = data_we_i ? wdata_i : out_reg;
      oe_next = dir_we_i ? wdata_i : oe_reg;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         // Input mode after reset keeps pins safe
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
      end
      else
      begin
         out_reg <= out_next;
         oe_reg <= oe_next;
      end
   end

   assign out_o = out_reg;
   assign oe_o = oe_reg;

endmodule : bmd_port_bit

// [hdl/bmd_bank0_decode.sv]
// Module: bank-0 address decoder, direct page and bus pin function switch
`timescale 1ns/1ps
module bmd_bank0_decode
   import bmd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic mode_select_pin_i,
   input wire logic mode_micro_i,
   input wire logic bus_byte_i,
   input wire bmd_req_s req_i,
   input wire logic [7:0] wdata_i,
   input wire logic [15:0] dp_base_wdata_i,
   input wire logic dp_base_we_i,
   input wire logic [8:0] port_data_we_i,
   input wire logic [8:0] port_dir_we_i,
   input wire logic phi_sel_we_i,
   input wire logic [7:0] bus_data_i,
   input wire logic [7:0] bus_data_hi_i,
   input wire logic [7:0] p4_pins_i,
   input wire logic [7:0] p7_pins_i,
   output bmd_dec_s dec_o,
   output logic [15:0] direct_page_base_o,
   output bmd_mode_e mode_o,
   output logic bus_wide_o,
   output logic enable_n_o,
   output bmd_pin_s p0_o,
   output bmd_pin_s p1_o,
   output bmd_pin_s p2_o,
   output bmd_pin_s p3_o,
   output bmd_pin_s p4_o,
   output logic hold_req_o,
   output logic ready_o,
   output logic ad_trigger_o,
   output logic [7:0] bus_rdata_o,
   output logic [7:0] bus_rdata_hi_o
);

   // ----------------------------------------------------------------
   // General-purpose port bits, ports 0 to 4
   // ----------------------------------------------------------------
   logic [4:0][7:0] gp_out;
   logic [4:0][7:0] gp_oe;

   genvar gp;
   genvar gb;
   generate
      for (gp = 0; gp < 5; gp++)
      begin : g_port
         for (gb = 0; gb < 8; gb++)
         begin : g_bit
            bmd_port_bit u_bit (
               .sys_clk_i(sys_clk_i),
               .reset_i(reset_i),
               .data_we_i(port_data_we_i[gp]),
               .dir_we_i(port_dir_we_i[gp]),
               .wdata_i(wdata_i[gb]),
               .out_o(gp_out[gp][gb]),
               .oe_o(gp_oe[gp][gb])
            );
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Mode, direct page and clock divider state
   // ----------------------------------------------------------------
   bmd_mode_e mode_reg;
   bmd_mode_e mode_next;
   logic [15:0] dp_base_reg;
   logic [15:0] dp_base_next;
   logic phi_sel_reg;
   logic phi_sel_next;
   logic phi_reg;
   logic phi_next;
   logic wide_reg;
   logic wide_next;
   logic mode_seen_reg;
   logic mode_seen_next;

   always_comb
   begin
      mode_next = mode_reg;
      mode_seen_next = 1'b1;
      // Pin caught once after reset release, not under reset
      if (!mode_seen_reg)
      begin
         if (!mode_select_pin_i)
            mode_next = BMD_MODE_SINGLE;
         else if (mode_micro_i)
            mode_next = BMD_MODE_MICRO;
         else
            mode_next = BMD_MODE_EXPAND;
      end
      dp_base_next = dp_base_we_i ? dp_base_wdata_i : dp_base_reg;
      phi_sel_next = phi_sel_we_i ? wdata_i[BMD_P4_PHI] : phi_sel_reg;
      phi_next = ~phi_reg;
      wide_next = ~bus_byte_i;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         mode_reg <= BMD_MODE_SINGLE;
         mode_seen_reg <= 1'b0;
         dp_base_reg <= BMD_DP_BASE_RST;
         phi_sel_reg <= BMD_PHI_SEL_RST;
         phi_reg <= 1'b0;
         wide_reg <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         mode_seen_reg <= mode_seen_next;
         dp_base_reg <= dp_base_next;
         phi_sel_reg <= phi_sel_next;
         phi_reg <= phi_next;
         wide_reg <= wide_next;
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   bmd_dec_s dec_reg;
   bmd_dec_s dec_next;
   logic enable_n_reg;
   logic enable_n_next;
   logic ale_reg;
   logic ale_next;
   logic rw_reg;
   logic rw_next;
   logic bhe_reg;
   logic bhe_next;

   always_comb
   begin
      logic [23:0] eff;
      logic [15:0] dp_sum;
      logic in_bank0;
      logic expand;
      eff = req_i.addr;
      dp_sum = 16'h0000;
      in_bank0 = 1'b0;
      expand = (mode_reg != BMD_MODE_SINGLE);
      if (req_i.direct)
      begin
         // Wraps inside bank 0, never spills into bank 1
         dp_sum = dp_base_reg + {8'h00, req_i.dp_offset};
         eff = {BMD_BANK_ZERO, dp_sum};
      end
      in_bank0 = (eff[23:16] == BMD_BANK_ZERO);
      dec_next = '0;
      dec_next.addr = eff;
      if (req_i.valid)
      begin
         if (in_bank0 && eff[15:0] <= BMD_SFR_LAST)
            dec_next.sfr = 1'b1;
         else if (in_bank0 && eff[15:0] >= BMD_RAM_FIRST && eff[15:0] <= BMD_RAM_LAST)
            dec_next.ram = 1'b1;
         else if (in_bank0 && eff[15:0] >= BMD_ROM_FIRST)
         begin
            dec_next.rom = 1'b1;
            dec_next.vector = (eff[15:0] >= BMD_VEC_FIRST);
         end
         else
            dec_next.ext = expand;
      end
      // Address phase while high, data phase while low
      enable_n_next = !(dec_next.ext);
      ale_next = dec_next.ext;
      rw_next = !(dec_next.ext && req_i.write);
      bhe_next = !(dec_next.ext && req_i.byte_hi && wide_reg);
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         dec_reg <= '0;
         enable_n_reg <= 1'b1;
         ale_reg <= 1'b0;
         rw_reg <= 1'b1;
         bhe_reg <= 1'b1;
      end
      else
      begin
         dec_reg <= dec_next;
         enable_n_reg <= enable_n_next;
         ale_reg <= ale_next;
         rw_reg <= rw_next;
         bhe_reg <= bhe_next;
      end
   end

   // ----------------------------------------------------------------
   // Pin function switch
   // ----------------------------------------------------------------
   bmd_pin_s p0_reg;
   bmd_pin_s p1_reg;
   bmd_pin_s p2_reg;
   bmd_pin_s p3_reg;
   bmd_pin_s p4_reg;
   bmd_pin_s p0_next;
   bmd_pin_s p1_next;
   bmd_pin_s p2_next;
   bmd_pin_s p3_next;
   bmd_pin_s p4_next;
   logic hold_reg;
   logic hold_next;
   logic ready_reg;
   logic ready_next;
   logic trig_reg;
   logic trig_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] rdata_hi_reg;
   logic [7:0] rdata_hi_next;

   always_comb
   begin
      logic expand;
      logic data_phase;
      expand = (mode_reg != BMD_MODE_SINGLE);
      data_phase = expand && !enable_n_reg;
      p0_next = '{out: gp_out[0], oe: gp_oe[0]};
      p1_next = '{out: gp_out[1], oe: gp_oe[1]};
      p2_next = '{out: gp_out[2], oe: gp_oe[2]};
      p3_next = '{out: gp_out[3], oe: gp_oe[3]};
      p4_next = '{out: gp_out[4], oe: gp_oe[4]};
      hold_next = 1'b0;
      ready_next = 1'b1;
      rdata_next = rdata_reg;
      rdata_hi_next = rdata_hi_reg;
      if (expand)
      begin
         p0_next = '{out: dec_next.addr[7:0], oe: 8'hff};
         // Multiplexed when the bus is wide: address while enable high, data while low
         p1_next = '{out: dec_next.addr[15:8], oe: 8'hff};
         p2_next = '{out: dec_next.addr[23:16], oe: 8'hff};
         // Data cycle lines up with enable low; pins driven only on a write
         if (dec_next.ext)
         begin
            p2_next = '{out: wdata_i, oe: {8{!rw_next}}};
            if (wide_reg)
               p1_next = '{out: wdata_i, oe: {8{!rw_next}}};
         end
         // Read data taken at the end of the enable-low cycle
         if (data_phase)
         begin
            rdata_next = bus_data_i;
            rdata_hi_next = wide_reg ? bus_data_hi_i : BMD_PORT_RST;
         end
         p3_next.out[BMD_P3_RW] = rw_reg;
         p3_next.out[BMD_P3_BHE] = bhe_reg;
         p3_next.out[BMD_P3_ALE] = ale_reg;
         p3_next.out[BMD_P3_HOLD_ACK_OUT] = !hold_reg;
         p3_next.oe[3:0] = 4'hf;
         // Active-low inputs driven by the outside
         p4_next.oe[BMD_P4_HOLD] = 1'b0;
         p4_next.oe[BMD_P4_RDY] = 1'b0;
         hold_next = !p4_pins_i[BMD_P4_HOLD];
         ready_next = !p4_pins_i[BMD_P4_RDY];
      end
      if (mode_reg == BMD_MODE_MICRO || phi_sel_reg)
      begin
         p4_next.out[BMD_P4_PHI] = phi_reg;
         p4_next.oe[BMD_P4_PHI] = 1'b1;
      end
      trig_next = !p7_pins_i[BMD_P7_TRIG];
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         p0_reg <= '0;
         p1_reg <= '0;
         p2_reg <= '0;
         p3_reg <= '0;
         p4_reg <= '0;
         hold_reg <= 1'b0;
         ready_reg <= 1'b1;
         trig_reg <= 1'b0;
         rdata_reg <= BMD_PORT_RST;
         rdata_hi_reg <= BMD_PORT_RST;
      end
      else
      begin
         p0_reg <= p0_next;
         p1_reg <= p1_next;
         p2_reg <= p2_next;
         p3_reg <= p3_next;
         p4_reg <= p4_next;
         hold_reg <= hold_next;
         ready_reg <= ready_next;
         trig_reg <= trig_next;
         rdata_reg <= rdata_next;
         rdata_hi_reg <= rdata_hi_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign dec_o = dec_reg;
   assign direct_page_base_o = dp_base_reg;
   assign mode_o = mode_reg;
   assign bus_wide_o = wide_reg;
   assign enable_n_o = enable_n_reg;
   assign p0_o = p0_reg;
   assign p1_o = p1_reg;
   assign p2_o = p2_reg;
   assign p3_o = p3_reg;
   assign p4_o = p4_reg;
   assign hold_req_o = hold_reg;
   assign ready_o = ready_reg;
   assign ad_trigger_o = trig_reg;
   assign bus_rdata_o = rdata_reg;
   assign bus_rdata_hi_o = rdata_hi_reg;

endmodule : bmd_bank0_decode

// [tb/bmd_monitor.sv]
// Checker: bank-0 decode, direct page and pin function assertions
`timescale 1ns/1ps
module bmd_monitor
   import bmd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire bmd_req_s req_i,
   input wire logic [7:0] p4_pins_i,
   input wire logic [7:0] p7_pins_i,
   input wire bmd_dec_s dec_o,
   input wire logic [15:0] direct_page_base_o,
   input wire bmd_mode_e mode_o,
   input wire logic enable_n_o,
   input wire bmd_pin_s p3_o,
   input wire bmd_pin_s p4_o,
   input wire logic hold_req_o,
   input wire logic ready_o,
   input wire logic ad_trigger_o
);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   logic flat;
   logic bank0;
   assign flat = req_i.valid && !req_i.direct;
   assign bank0 = req_i.addr[23:16] == BMD_BANK_ZERO;
   chk_sfr_select: assert property (flat && bank0 && req_i.addr[15:0] <= BMD_SFR_LAST
      |=> dec_o.sfr && !dec_o.ram && !dec_o.ext) else $error("control register select wrong");
   chk_ram_select: assert property (flat && bank0 && req_i.addr[15:0] >= BMD_RAM_FIRST
      && req_i.addr[15:0] <= BMD_RAM_LAST |=> dec_o.ram && !dec_o.sfr) else $error("ram select wrong");
   // Micro mode left out: its upper area may be served from outside
   chk_rom_select: assert property (flat && bank0 && mode_o != BMD_MODE_MICRO
      && req_i.addr[15:0] >= BMD_ROM_FIRST |=> dec_o.rom
      && dec_o.vector == ($past(req_i.addr[15:0]) >= BMD_VEC_FIRST)) else $error("rom select wrong");
   chk_bank_only: assert property ((dec_o.sfr || dec_o.ram || dec_o.rom)
      |-> dec_o.addr[23:16] == BMD_BANK_ZERO) else $error("internal select outside bank 0");
   chk_ext_route: assert property (flat && !bank0 && mode_o != BMD_MODE_SINGLE
      |=> dec_o.ext && !enable_n_o) else $error("far bank not routed outside");
   chk_single_none: assert property (flat && !bank0 && mode_o == BMD_MODE_SINGLE
      |=> !dec_o.ext && enable_n_o) else $error("single-chip access went outside");
   chk_direct_page: assert property (req_i.valid && req_i.direct |=> dec_o.addr ==
      {8'h00, $past(direct_page_base_o) + 16'($past(req_i.dp_offset))}) else $error("dp addr");
   chk_strobe_pins: assert property ((mode_o != BMD_MODE_SINGLE)[*3]
      |-> p3_o.oe[3:0] == 4'hf) else $error("bus strobes not driven");
   chk_phi_micro: assert property ((mode_o == BMD_MODE_MICRO)[*3] |-> p4_o.oe[BMD_P4_PHI]
      && p4_o.out[BMD_P4_PHI] != $past(p4_o.out[BMD_P4_PHI])) else $error("clock pin idle");
   chk_hold_in: assert property ((mode_o != BMD_MODE_SINGLE && !p4_pins_i[BMD_P4_HOLD])[*2]
      |-> hold_req_o) else $error("hold request lost");
   chk_ready_in: assert property ((mode_o != BMD_MODE_SINGLE && p4_pins_i[BMD_P4_RDY])[*2]
      |-> !ready_o) else $error("ready shown while pin not ready");
   chk_trigger_in: assert property ((!p7_pins_i[BMD_P7_TRIG])[*2] |-> ad_trigger_o)
      else $error("trigger lost");
   cover property (flat && !bank0 && mode_o == BMD_MODE_EXPAND);
   cover property (req_i.valid && req_i.direct);
   cover property (mode_o == BMD_MODE_MICRO);
endmodule : bmd_monitor

bind bmd_bank0_decode bmd_monitor bmd_monitor_i (.sys_clk_i, .reset_i, .req_i, .p4_pins_i,
   .p7_pins_i, .dec_o, .direct_page_base_o, .mode_o, .enable_n_o, .p3_o, .p4_o, .hold_req_o,
   .ready_o, .ad_trigger_o);

// [tb/bmd_ext_mem.sv]
// Model: external memory on the multiplexed expansion bus
`timescale 1ns/1ps
module bmd_ext_mem
(
   input wire logic sys_clk_i,
   input wire logic enable_n_i,
   input wire logic [23:0] addr_i,
   input wire logic slow_i,
   output logic [7:0] data_o,
   output logic [7:0] data_hi_o,
   output logic ready_n_o
);
   // ----------------------------------------------------------------
   // Data phase
   // ----------------------------------------------------------------
   logic [7:0] last_lo = 8'h00;
   logic [7:0] last_hi = 8'h00;
   always @(posedge sys_clk_i)
   begin
      if (!enable_n_i)
      begin
         last_lo <= addr_i[7:0] ^ 8'h3c;
         last_hi <= addr_i[15:8];
      end
   end
   // Released bus shows the inverse so a late sample never matches
   assign data_o = enable_n_i ? ~last_lo : addr_i[7:0] ^ 8'h3c;
   assign data_hi_o = enable_n_i ? ~last_hi : addr_i[15:8];
   assign ready_n_o = slow_i;
endmodule : bmd_ext_mem

// [tb/tb_bank0_map_decode_and_bus_pins.sv]
// Testbench: bank-0 decoder, direct page and pin function checks
`timescale 1ns/1ps
module tb_bank0_map_decode_and_bus_pins
   import bmd_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic mode_select_pin_i = 1'b0, mode_micro_i = 1'b0, bus_byte_i = 1'b0;
   bmd_req_s req_i = '0;
   logic [7:0] wdata_i = 8'h00, p7_pins_i = 8'hff;
   logic [15:0] dp_base_wdata_i = 16'h0000, dpv;
   logic dp_base_we_i = 1'b0, phi_sel_we_i = 1'b0, slow = 1'b0, hold_n = 1'b1, rdy_n, ph;
   logic [8:0] port_data_we_i = 9'h000, port_dir_we_i = 9'h000;
   logic [5:0] p4hi = 6'h3f;
   wire logic [7:0] p4_pins_i, bus_data_i, bus_data_hi_i;
   bmd_dec_s dec_o;
   logic [15:0] direct_page_base_o;
   bmd_mode_e mode_o, em;
   logic bus_wide_o, enable_n_o, hold_req_o, ready_o, ad_trigger_o, vq = 1'b0;
   bmd_pin_s p0_o, p1_o, p2_o, p3_o, p4_o;
   logic [7:0] bus_rdata_o, bus_rdata_hi_o;
   logic [31:0] cur, pins;
   logic [23:0] xa;
   logic xq = 1'b0;
   logic [31:0] pq[$];
   int err_count = 0, checked = 0, cyc = 0;
   logic [31:0] expq[$];
   logic [23:0] tbl[12] = '{24'h000000, 24'h00007f, 24'h000080, 24'h00027f, 24'h000280,
      24'h00bfff, 24'h00c000, 24'h00ffd5, 24'h00ffd6, 24'h00ffff, 24'h010000, 24'hff0000};
   assign p4_pins_i = {p4hi, rdy_n, hold_n};

   bmd_bank0_decode bmd_bank0_decode_i (.sys_clk_i, .reset_i, .mode_select_pin_i, .mode_micro_i,
      .bus_byte_i, .req_i, .wdata_i, .dp_base_wdata_i, .dp_base_we_i, .port_data_we_i,
      .port_dir_we_i, .phi_sel_we_i, .bus_data_i, .bus_data_hi_i, .p4_pins_i, .p7_pins_i, .dec_o,
      .direct_page_base_o, .mode_o, .bus_wide_o, .enable_n_o, .p0_o, .p1_o, .p2_o, .p3_o,
      .p4_o, .hold_req_o, .ready_o, .ad_trigger_o, .bus_rdata_o, .bus_rdata_hi_o);
   bmd_ext_mem bmd_ext_mem_i (.sys_clk_i, .enable_n_i(enable_n_o), .addr_i(dec_o.addr),
      .slow_i(slow), .data_o(bus_data_i), .data_hi_o(bus_data_hi_i), .ready_n_o(rdy_n));

   // ----------------------------------------------------------------
   // Checking and run control
   // ----------------------------------------------------------------
   always #10 sys_clk_i = ~sys_clk_i;
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic stop_test;
      if (err_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   // Ceiling well above the roughly 200 cycles the run needs
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         stop_test();
      end
   end
   function automatic logic [31:0] expect_dec(input logic [23:0] a);
      logic b0, s, r, o;
      b0 = a[23:16] == 8'h00;
      s = b0 && a[15:0] <= BMD_SFR_LAST;
      r = b0 && a[15:0] >= BMD_RAM_FIRST && a[15:0] <= BMD_RAM_LAST;
      o = b0 && a[15:0] >= BMD_ROM_FIRST;
      return {3'h0, s, r, o, o && a[15:0] >= BMD_VEC_FIRST, em != BMD_MODE_SINGLE && !(s||r||o), a};
   endfunction : expect_dec
   // Caller lowers valid after the last of a burst, never between
   task automatic access(input logic dir, input logic [23:0] a, input logic [7:0] off);
      logic [23:0] e;
      e = dir ? {8'h00, dpv + {8'h00, off}} : a;
      req_i.valid = 1'b1;
      req_i.direct = dir;
      req_i.write = 1'($urandom);
      req_i.byte_hi = 1'($urandom);
      req_i.addr = a;
      req_i.dp_offset = off;
      wdata_i = 8'($urandom);
      expq.push_back(expect_dec(e));
      pq.push_back({e[7:0], bus_byte_i ? e[15:8] : wdata_i, wdata_i, {8{req_i.write}}});
      @(negedge sys_clk_i);
   endtask : access
   always @(posedge sys_clk_i)
      vq <= req_i.valid && !reset_i;
   // Read data lands one cycle after the select, at the end of enable low
   always @(negedge sys_clk_i)
   begin
      if (xq)
         check({16'h0, bus_rdata_hi_o, bus_rdata_o}, {16'h0, xa[15:8], xa[7:0] ^ 8'h3c});
      xq = 1'b0;
      if (vq)
      begin
         cur = expq.pop_front();
         pins = pq.pop_front();
         check({3'h0, dec_o}, cur);
         xq = cur[24];
         xa = cur[23:0];
         if (cur[24])
            check({p0_o.out, p1_o.out, p2_o.out, p2_o.oe}, pins);
      end
   end
   task automatic wait_chk(input logic seen_sel, input logic [31:0] want);
      repeat (3) @(negedge sys_clk_i);
      check({31'h0, seen_sel ? ad_trigger_o : hold_req_o}, want);
   endtask : wait_chk

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      logic [23:0] a;
      void'($urandom(32'h3659));
      for (int k = 0; k < 3; k++)
      begin
         em = bmd_mode_e'(k);
         dpv = BMD_DP_BASE_RST;
         mode_select_pin_i = k != 0;
         mode_micro_i = k == 2;
         reset_i = 1'b1;
         repeat (20) @(negedge sys_clk_i);
         reset_i = 1'b0;
         repeat (3) @(negedge sys_clk_i);
         check({30'h0, mode_o}, {30'h0, em});
         if (k < 2)
         begin
            foreach (tbl[i])
               access(1'b0, tbl[i], 8'h00);
            for (int n = 0; n < 24; n++)
            begin
               a = 24'($urandom);
               a[23:16] = n[0] ? 8'h00 : a[23:16];
               access(1'b0, a, 8'h00);
            end
            req_i.valid = 1'b0;
            dp_base_wdata_i = 16'hffc0;
            dp_base_we_i = 1'b1;
            @(negedge sys_clk_i);
            dp_base_we_i = 1'b0;
            dpv = 16'hffc0;
            @(negedge sys_clk_i);
            check({16'h0, direct_page_base_o}, 32'h0000ffc0);
            access(1'b1, 24'h000000, 8'h50);
            access(1'b1, 24'h000000, 8'h3f);
            req_i.valid = 1'b0;
            wdata_i = 8'h04;
            phi_sel_we_i = 1'b1;
            @(negedge sys_clk_i);
            phi_sel_we_i = 1'b0;
         end
         repeat (3) @(negedge sys_clk_i);
         ph = p4_o.out[BMD_P4_PHI];
         @(negedge sys_clk_i);
         check({30'h0, p4_o.oe[BMD_P4_PHI], p4_o.out[BMD_P4_PHI]}, {30'h0, 1'b1, ~ph});
         p7_pins_i = 8'h7f;
         wait_chk(1'b1, 32'h1);
         p7_pins_i = 8'hff;
         wait_chk(1'b1, 32'h0);
         if (k == 0)
         begin
            wdata_i = 8'ha5;
            port_dir_we_i = 9'h009;
            @(negedge sys_clk_i);
            port_dir_we_i = 9'h000;
            wdata_i = 8'h5a;
            port_data_we_i = 9'h009;
            @(negedge sys_clk_i);
            port_data_we_i = 9'h000;
            repeat (2) @(negedge sys_clk_i);
            check({p0_o.oe, p3_o.oe, p0_o.out, p3_o.out}, 32'ha5a55a5a);
         end
         else
         begin
            hold_n = 1'b0;
            slow = 1'b1;
            bus_byte_i = 1'b1;
            wait_chk(1'b0, 32'h1);
            check({30'h0, ready_o, bus_wide_o}, 32'h0);
            hold_n = 1'b1;
            slow = 1'b0;
            bus_byte_i = 1'b0;
            wait_chk(1'b0, 32'h0);
            check({30'h0, ready_o, bus_wide_o}, 32'h3);
         end
      end
      stop_test();
   end
endmodule : tb_bank0_map_decode_and_bus_pins
